/* design/srsc_pkg.sv */
package srsc_pkg;
    localparam logic [11:0] ADDR_CAUSE    = 12'h000;
    localparam logic [11:0] ADDR_DBGCTL   = 12'h004;
    localparam logic [11:0] ADDR_CTRL     = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;

    localparam int CAUSE_POR    = 0;
    localparam int CAUSE_EXT    = 1;
    localparam int CAUSE_WDT    = 2;
    localparam int CAUSE_DBGPIN = 3;
    localparam int CAUSE_W      = 4;

    localparam int DBGCTL_RST   = 0;
    localparam int CTRL_WDT_RST = 0;
    localparam int IRQ_WDT      = 0;
    localparam int IRQ_DONE     = 1;
    localparam int IRQ_W        = 2;

    localparam logic [3:0] CAUSE_RST = 4'h1;
    localparam logic       CTRL_RST  = 1'b1;
    localparam logic [1:0] MASK_RST  = 2'h0;

    localparam int EXT_MIN_CYCLES  = 3;
    localparam int CLK_MHZ         = 200;
    localparam int RESET_DELAY_NS  = 1000;
    localparam int RESET_DELAY_CYC = (RESET_DELAY_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HOLD,
        ST_COUNT,
        ST_PIN_WAIT
    } srsc_state_e;
endpackage : srsc_pkg

/* design/srsc_delay_counter.sv */
`timescale 1ns/1ps
module srsc_delay_counter #(
    parameter int COUNT = srsc_pkg::RESET_DELAY_CYC,
    parameter int W     = 16
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output logic      done_r
);
    logic [W-1:0] cnt_r;
    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    initial begin
        if (COUNT < 1 || COUNT > (1 << W) - 1) begin
            $error("srsc_delay_counter: COUNT out of range");
        end
    end

    // Clears whenever not running so every reset gets the full delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else if (!run) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= (cnt_r == LAST);
            if (cnt_r != LAST) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule : srsc_delay_counter

/* design/srsc_top.sv */
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] - Power or brownout reset delay counts only after supply-good is seen.
// [R2] - In run or halt, watchdog time-out resets when reset mode selected.
// [R3] - In run or halt, reset pin lows under three cycles are ignored.
// [R4] - Debugger control bit 0 resets everything except the debug unit.
// [R5] - In stop mode, the analog filtered reset pin decides, not cycle counts.
// [R6] - In stop mode, debug pin low starts a system reset.
// [R7] - Three-cycle pin low may reset; four or more always resets.
// [R8] - Pin held past the delay keeps reset until the edge after release.
// [R9] - Reset from the external pin sets the external reset flag.
// [R10] - Debugger reset bit self-clears in reset; power-on flag then reads set.
module srsc_top #(
    parameter int DELAY_CYCLES = srsc_pkg::RESET_DELAY_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        brownout_detect,
    input  wire logic        supply_good,
    input  wire logic        wdt_timeout,
    input  wire logic        stop_mode,
    input  wire logic        reset_pin_i,
    input  wire logic        reset_pin_filt_i,
    input  wire logic        debug_pin_i,
    output logic             reset_pin_o,
    output logic             reset_pin_oe_n,
    output logic             sys_reset_n,
    output logic             debug_unit_reset_n,
    output logic             irq
);
    localparam logic [1:0] EXT_MAX = 2'(srsc_pkg::EXT_MIN_CYCLES);

    initial begin
        if (DELAY_CYCLES < 1 || DELAY_CYCLES > 65535) begin
            $error("srsc_top: DELAY_CYCLES out of range");
        end
    end

    // Two-flop synchronisers for every analog or pin input
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 6'h3E;
            sync2_r <= 6'h3E;
        end else begin
            sync1_r <= {debug_pin_i, reset_pin_filt_i, reset_pin_i, supply_good,
                        1'b1, brownout_detect};
            sync2_r <= sync1_r;
        end
    end
    logic bod_s, good_s, pin_s, filt_s, dbgpin_s;
    assign bod_s    = sync2_r[0];
    assign good_s   = sync2_r[2];
    assign pin_s    = sync2_r[3];
    assign filt_s   = sync2_r[4];
    assign dbgpin_s = sync2_r[5];

    srsc_pkg::srsc_state_e     state_r, state_nxt;
    logic [1:0]                low_cnt_r;
    logic [srsc_pkg::CAUSE_W-1:0] cause_r;
    logic                      dbgctl_rst_r, ctrl_wdt_rst_r;
    logic [srsc_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r;
    logic                      sys_rst_n_r, dbg_rst_n_r, pin_oe_n_r;
    logic                      cnt_done;

    // Pin filter counts consecutive low samples only while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_r <= '0;
        end else if (pin_s || stop_mode || state_r != srsc_pkg::ST_RUN) begin
            low_cnt_r <= '0;
        end else if (low_cnt_r != EXT_MAX) begin
            low_cnt_r <= low_cnt_r + 1'b1; // [R3] [R7]
        end
    end

    logic src_por, src_ext, src_wdt, src_dbgpin, src_ocd, any_src;
    assign src_por    = bod_s || !good_s;
    assign src_ext    = stop_mode ? !filt_s : (low_cnt_r == EXT_MAX); // [R3] [R5] [R7]
    assign src_wdt    = wdt_timeout && ctrl_wdt_rst_r && !stop_mode; // [R2]
    assign src_dbgpin = stop_mode && !dbgpin_s; // [R6]
    assign src_ocd    = dbgctl_rst_r; // [R4]
    assign any_src    = src_por || src_ext || src_wdt || src_dbgpin || src_ocd;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            srsc_pkg::ST_RUN: begin
                if (any_src) begin
                    state_nxt = srsc_pkg::ST_HOLD;
                end
            end
            srsc_pkg::ST_HOLD: begin
                if (!src_por && !src_dbgpin) begin
                    state_nxt = srsc_pkg::ST_COUNT; // [R1]
                end
            end
            srsc_pkg::ST_COUNT: begin
                if (src_por || src_dbgpin) begin
                    state_nxt = srsc_pkg::ST_HOLD; // [R1]
                end else if (cnt_done) begin
                    state_nxt = pin_s ? srsc_pkg::ST_RUN : srsc_pkg::ST_PIN_WAIT; // [R8]
                end
            end
            srsc_pkg::ST_PIN_WAIT: begin
                if (pin_s) begin
                    state_nxt = srsc_pkg::ST_RUN; // [R8]
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= srsc_pkg::ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    srsc_delay_counter #(
        .COUNT (DELAY_CYCLES),
        .W     (16)
    ) u_delay (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (state_r == srsc_pkg::ST_COUNT && !cnt_done),
        .done_r  (cnt_done)
    );

    // Debug unit only follows supply loss, never the debugger request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_rst_n_r <= 1'b0;
            dbg_rst_n_r <= 1'b0;
            pin_oe_n_r  <= 1'b1;
        end else begin
            sys_rst_n_r <= (state_nxt == srsc_pkg::ST_RUN);
            dbg_rst_n_r <= !src_por; // [R4]
            // Drive the pin only up to the delay end; waiting on it must not hold it low
            pin_oe_n_r  <= !(state_nxt == srsc_pkg::ST_HOLD || state_nxt == srsc_pkg::ST_COUNT);
        end
    end

    // APB: zero wait, read data captured in the setup cycle
    logic wr_en, rd_setup, addr_ok;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_ok  = (paddr == srsc_pkg::ADDR_CAUSE) || (paddr == srsc_pkg::ADDR_DBGCTL) ||
                      (paddr == srsc_pkg::ADDR_CTRL) || (paddr == srsc_pkg::ADDR_IRQ_STAT) ||
                      (paddr == srsc_pkg::ADDR_IRQ_MASK);

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    logic dbgctl_wr;
    assign dbgctl_wr = wr_en && hit(paddr, srsc_pkg::ADDR_DBGCTL);

    logic [srsc_pkg::CAUSE_W-1:0] cause_set;
    assign cause_set = (state_r == srsc_pkg::ST_RUN) ?
                       {src_dbgpin, src_wdt, src_ext, src_por || src_ocd} : // [R9] [R10]
                       {3'h0, src_por};

    // Set wins over the write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r <= srsc_pkg::CAUSE_RST;
        end else begin
            cause_r <= (cause_r & ~((wr_en && hit(paddr, srsc_pkg::ADDR_CAUSE)) ?
                       pwdata[srsc_pkg::CAUSE_W-1:0] : 4'h0)) | cause_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbgctl_rst_r <= 1'b0;
        end else if (dbgctl_wr && pwdata[srsc_pkg::DBGCTL_RST]) begin
            dbgctl_rst_r <= 1'b1; // [R4]
        end else if (state_r == srsc_pkg::ST_COUNT) begin
            dbgctl_rst_r <= 1'b0; // [R10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_wdt_rst_r <= srsc_pkg::CTRL_RST;
            irq_mask_r     <= srsc_pkg::MASK_RST;
        end else if (wr_en && hit(paddr, srsc_pkg::ADDR_CTRL)) begin
            ctrl_wdt_rst_r <= pwdata[srsc_pkg::CTRL_WDT_RST];
        end else if (wr_en && hit(paddr, srsc_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_r <= pwdata[srsc_pkg::IRQ_W-1:0];
        end
    end

    logic [srsc_pkg::IRQ_W-1:0] irq_set;
    assign irq_set = {state_r != srsc_pkg::ST_RUN && state_nxt == srsc_pkg::ST_RUN,
                      wdt_timeout && !ctrl_wdt_rst_r && !stop_mode};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~((wr_en && hit(paddr, srsc_pkg::ADDR_IRQ_STAT)) ?
                          pwdata[srsc_pkg::IRQ_W-1:0] : 2'h0)) | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            unique case (1'b1)
                hit(paddr, srsc_pkg::ADDR_CAUSE):    prdata <= {28'h000_0000, cause_r};
                hit(paddr, srsc_pkg::ADDR_DBGCTL):   prdata <= {31'h0, dbgctl_rst_r};
                hit(paddr, srsc_pkg::ADDR_CTRL):     prdata <= {31'h0, ctrl_wdt_rst_r};
                hit(paddr, srsc_pkg::ADDR_IRQ_STAT): prdata <= {30'h0, irq_stat_r};
                hit(paddr, srsc_pkg::ADDR_IRQ_MASK): prdata <= {30'h0, irq_mask_r};
                default:                             prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign pready             = 1'b1;
    assign pslverr            = psel && penable && !addr_ok;
    assign reset_pin_o        = 1'b0;
    assign reset_pin_oe_n     = pin_oe_n_r;
    assign sys_reset_n        = sys_rst_n_r;
    assign debug_unit_reset_n = dbg_rst_n_r;
    assign irq                = |(irq_stat_r & irq_mask_r);

    logic run_st;
    assign run_st = (state_r == srsc_pkg::ST_RUN);

    sequence s_low4;
        (run_st && !stop_mode && !pin_s)[*4];
    endsequence
    sequence s_enter;
        ##1 !sys_reset_n;
    endsequence

    property p_count_supply;
        @(posedge pclk) disable iff (!presetn)
        (state_r == srsc_pkg::ST_COUNT) |-> $past(good_s);
    endproperty
    a_count_supply: assert property (p_count_supply) else $error("count without supply"); // [R1]

    property p_wdt_reset;
        @(posedge pclk) disable iff (!presetn)
        (run_st && wdt_timeout && ctrl_wdt_rst_r && !stop_mode) |-> s_enter;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missed"); // [R2]

    property p_glitch;
        @(posedge pclk) disable iff (!presetn)
        (run_st && !stop_mode && low_cnt_r < EXT_MAX && !src_por && !src_wdt && !src_ocd)
        |=> run_st;
    endproperty
    a_glitch: assert property (p_glitch) else $error("short pin pulse reset"); // [R3]

    property p_debug_kept;
        @(posedge pclk) disable iff (!presetn)
        (src_ocd && !src_por) |=> debug_unit_reset_n;
    endproperty
    a_debug_kept: assert property (p_debug_kept) else $error("debug unit reset"); // [R4]

    property p_stop_pin;
        @(posedge pclk) disable iff (!presetn)
        (run_st && stop_mode && !filt_s) |-> s_enter;
    endproperty
    a_stop_pin: assert property (p_stop_pin) else $error("stop pin reset missed"); // [R5]

    property p_stop_dbg;
        @(posedge pclk) disable iff (!presetn)
        (run_st && stop_mode && !dbgpin_s) |-> s_enter;
    endproperty
    a_stop_dbg: assert property (p_stop_dbg) else $error("debug pin reset missed"); // [R6]

    property p_low4;
        @(posedge pclk) disable iff (!presetn)
        s_low4 |=> !run_st;
    endproperty
    a_low4: assert property (p_low4) else $error("four-cycle pulse ignored"); // [R7]

    property p_pin_release;
        @(posedge pclk) disable iff (!presetn)
        (state_r == srsc_pkg::ST_PIN_WAIT) |-> (!sys_reset_n and (pin_s |=> sys_reset_n));
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin release exit wrong"); // [R8]

    property p_ext_flag;
        @(posedge pclk) disable iff (!presetn)
        (run_st && src_ext) |=> cause_r[srsc_pkg::CAUSE_EXT];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("external flag not set"); // [R9]

    property p_ocd_clear;
        @(posedge pclk) disable iff (!presetn)
        (run_st && src_ocd) |=> cause_r[srsc_pkg::CAUSE_POR] ##[1:8] !dbgctl_rst_r;
    endproperty
    a_ocd_clear: assert property (p_ocd_clear) else $error("debugger bit not cleared"); // [R10]
endmodule : srsc_top

/* tb/srsc_pin_host.sv */
`timescale 1ns/1ps
module srsc_pin_host #(
    parameter int FILT = 8
) (
    input  wire logic pclk,
    input  wire logic dev_pin_o,
    input  wire logic dev_oe_n,
    input  wire logic ext_low,
    input  wire logic dbg_low,
    output logic      pin,
    output logic      pin_filt,
    output logic      dbg_pin
);
    int run_low = 0;
    // Pull-up wins only when nobody sinks the wire
    assign pin = ((!dev_oe_n && !dev_pin_o) || ext_low) ? 1'b0 : 1'b1;
    // Crude analog filter; longer than the device's own drive, so no re-trigger
    always @(posedge pclk) run_low <= pin ? 0 : run_low + 1;
    assign pin_filt = (run_low >= FILT) ? 1'b0 : 1'b1;
    assign dbg_pin = !dbg_low;
endmodule : srsc_pin_host

/* tb/srsc_top_tb.sv */
`timescale 1ns/1ps
module srsc_top_tb;
    localparam int DLY = 4;
    logic pclk = 0, presetn, psel, penable, pwrite, brownout_detect, supply_good;
    logic wdt_timeout, stop_mode, ext_low, dbg_low;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic pready, pslverr, re, pin, pin_filt, dbg_pin, reset_pin_o, reset_pin_oe_n;
    logic sys_reset_n, debug_unit_reset_n, irq;
    int n_fail = 0, compares = 0, wc, du_low = 0;

    srsc_top #(.DELAY_CYCLES(DLY)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .brownout_detect(brownout_detect), .supply_good(supply_good),
        .wdt_timeout(wdt_timeout), .stop_mode(stop_mode), .reset_pin_i(pin),
        .reset_pin_filt_i(pin_filt), .debug_pin_i(dbg_pin), .reset_pin_o(reset_pin_o),
        .reset_pin_oe_n(reset_pin_oe_n), .sys_reset_n(sys_reset_n),
        .debug_unit_reset_n(debug_unit_reset_n), .irq(irq));
    srsc_pin_host host (.pclk(pclk), .dev_pin_o(reset_pin_o), .dev_oe_n(reset_pin_oe_n),
        .ext_low(ext_low), .dbg_low(dbg_low), .pin(pin), .pin_filt(pin_filt),
        .dbg_pin(dbg_pin));

    always #2.5 pclk = ~pclk;
    always @(negedge pclk) if (debug_unit_reset_n !== 1'b1) du_low++;

    task results;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rv = prdata;
        re = pslverr;
        psel <= 0; penable <= 0;
        if (k >= 20) begin
            n_fail++;
            $display("mismatch pready exp 1 got %b", pready);
            results();
        end
    endtask : apb

    task wt(input logic v, input int lim);
        wc = 0;
        while (sys_reset_n !== v && wc < lim) begin
            @(negedge pclk);
            wc++;
        end
        if (wc >= lim) begin
            n_fail++;
            $display("mismatch sys_reset_n exp %b got %b", v, sys_reset_n);
            results();
        end
    endtask : wt

    task stay(input logic v, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(negedge pclk);
            if (sys_reset_n !== v) bad++;
        end
        chk("sys_reset_n_level", 32'h0000_0000, 32'(bad));
    endtask : stay

    task pulse_pin(input int n);
        @(posedge pclk) ext_low <= 1;
        repeat (n) @(posedge pclk);
        ext_low <= 0;
    endtask : pulse_pin

    task pulse_wdt;
        @(posedge pclk) wdt_timeout <= 1;
        @(posedge pclk) wdt_timeout <= 0;
    endtask : pulse_wdt

    task cause(input logic [3:0] e);
        apb(0, srsc_pkg::ADDR_CAUSE, 32'h0000_0000);
        chk("reset_cause", 32'(e), rv);
        apb(1, srsc_pkg::ADDR_CAUSE, 32'h0000_000F);
    endtask : cause

    initial begin
        {psel, penable, pwrite, wdt_timeout, stop_mode, ext_low, dbg_low} = 0;
        brownout_detect = 0; supply_good = 1; paddr = 0; pwdata = 0; presetn = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        wt(1, 100);
        cause(4'h1);
        apb(0, srsc_pkg::ADDR_CTRL, 0);     chk("ctrl", 1, rv);
        apb(0, srsc_pkg::ADDR_IRQ_MASK, 0); chk("mask", 0, rv);
        apb(0, 12'h0FC, 0);
        chk("unmapped_err", 1, 32'(re));
        chk("unmapped_data", 0, rv);
        $display("test registers done");
        // Supply dip: held in reset, delay counted only once supply is good
        du_low = 0;
        supply_good <= 0; wt(0, 20); stay(0, 30);
        chk("debug_unit_reset", 1, 32'(du_low > 0));
        chk("pin_drive", 0, 32'(reset_pin_oe_n));
        @(posedge pclk) supply_good <= 1;
        wt(1, 100);
        chk("por_delay", 1, 32'(wc > DLY));
        chk("pin_free", 1, 32'(reset_pin_oe_n));
        cause(4'h1);
        $display("test power done");
        pulse_pin(2); stay(1, 12); cause(4'h0);
        pulse_pin(4); wt(0, 12); wt(1, 100); cause(4'h2);
        ext_low <= 1; wt(0, 10); stay(0, 40);
        @(posedge pclk) ext_low <= 0;
        wt(1, 12);
        chk("pin_exit", 1, 32'(wc <= 5));
        cause(4'h2);
        $display("test pin done");
        pulse_wdt; wt(0, 5); wt(1, 100); cause(4'h4);
        apb(1, srsc_pkg::ADDR_CTRL, 0);
        apb(1, srsc_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
        pulse_wdt; stay(1, 8);
        apb(0, srsc_pkg::ADDR_IRQ_STAT, 0); chk("irq_stat", 1, rv);
        @(negedge pclk) chk("irq_masked", 0, 32'(irq));
        apb(1, srsc_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        @(negedge pclk) chk("irq_on", 1, 32'(irq));
        apb(1, srsc_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
        @(negedge pclk) chk("irq_off", 0, 32'(irq));
        apb(1, srsc_pkg::ADDR_CTRL, 32'h0000_0001);
        $display("test watchdog done");
        du_low = 0;
        apb(1, srsc_pkg::ADDR_DBGCTL, 32'h0000_0001); wt(0, 5);
        wt(1, 100);
        chk("debug_unit_kept", 0, 32'(du_low));
        apb(0, srsc_pkg::ADDR_DBGCTL, 0); chk("dbgctl", 0, rv);
        cause(4'h1);
        apb(0, srsc_pkg::ADDR_IRQ_STAT, 0);
        chk("irq_done", 2, rv);
        $display("test debugger done");
        // Stop: a 4-cycle low would reset in run, the analog filter drops it
        stop_mode <= 1;
        pulse_pin(4); stay(1, 14);
        pulse_wdt; stay(1, 8);
        pulse_pin(12); wt(0, 12); wt(1, 100); cause(4'h2);
        dbg_low <= 1; wt(0, 10);
        @(posedge pclk) dbg_low <= 0;
        wt(1, 100); cause(4'h8);
        stop_mode <= 0;
        $display("test stop done");
        results();
    end
endmodule : srsc_top_tb
